/* File: rtl/wdr_map.vh */
`ifndef WDR_MAP_VH
`define WDR_MAP_VH
// ----------------------------------------
// register offsets
// ----------------------------------------
`define WDR_ADDR_RELOAD 8'h86
`define WDR_ADDR_PRIO0 8'ha9
`define WDR_ADDR_INT_ENABLE_REG_ZERO 8'ha8
`define WDR_ADDR_INT_ENABLE_REG_ONE 8'hb8
// ----------------------------------------
// fields and values
// ----------------------------------------
`define WDR_BIT_WD 6
`define WDR_BIT_PRESEL 7
`define WDR_BIT_PRIO_WDT 6
`define WDR_TIMEOUT 16'h7cff
`define WDR_BASE_DIV 24
`define WDR_EXTRA_DIV 16
`define WDR_WINDOW 12
`define WDR_RST_HOLD 2
`endif

/* File: rtl/wdr_watchdog.v */
`timescale 1ns/1ns
`default_nettype none
`include "wdr_map.vh"
module wdr_watchdog #(
  parameter BASE_DIV = `WDR_BASE_DIV,
  parameter EXTRA_DIV = `WDR_EXTRA_DIV,
  parameter WINDOW = `WDR_WINDOW
) (
  // clock and reset
  input wire i_clock,
  input wire i_rst_n,
  // straps
  input wire i_auto_start,
  // register port
  input wire [7:0] i_addr,
  input wire [7:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  output reg [7:0] o_rdata,
  // status
  output reg o_running,
  output wire o_timeout,
  output reg o_prio_wdt,
  output reg o_reset_req,
  output wire o_int_rst
);
  // ----------------------------------------
  // internal reset: external low or request, stretched
  // ----------------------------------------
  wire int_rst;
  wire rst_cause;
  assign rst_cause = o_reset_req;
  wdr_rst_stretch #(
    .HOLD(`WDR_RST_HOLD),
    .CNT_W(2)
  ) i_rst_stretch (
    .i_clock(i_clock),
    .i_rst_n(i_rst_n),
    .i_cause(rst_cause),
    .o_int_rst(int_rst)
  );
  assign o_int_rst = int_rst;

  // ----------------------------------------
  // register decode
  // ----------------------------------------
  wire wr_reload;
  wire wr_int_enable_reg_zero;
  wire wr_int_enable_reg_one;
  wire set_arm;
  wire set_commit;
  assign wr_reload = i_wr && (i_addr == `WDR_ADDR_RELOAD);
  assign wr_int_enable_reg_zero = i_wr && (i_addr == `WDR_ADDR_INT_ENABLE_REG_ZERO);
  assign wr_int_enable_reg_one = i_wr && (i_addr == `WDR_ADDR_INT_ENABLE_REG_ONE);
  // only bit 6 of the two enable registers belongs to the watchdog
  assign set_arm = wr_int_enable_reg_zero && i_wdata[`WDR_BIT_WD];
  assign set_commit = wr_int_enable_reg_one && i_wdata[`WDR_BIT_WD];

  // ----------------------------------------
  // reload register
  // ----------------------------------------
  // writable even inside the internal reset; only the pin clears it
  reg [7:0] reload;
  wire presel;
  wire [6:0] reload_high;
  always @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      reload <= 8'h00;
    end else if (wr_reload) begin
      reload <= i_wdata;
    end
  end
  assign presel = reload[`WDR_BIT_PRESEL];
  assign reload_high = reload[6:0];

  // ----------------------------------------
  // refresh arm and commit flags
  // ----------------------------------------
  wire arm;
  wire commit;
  wire refresh;
  // commit only reloads while the arm flag still stands
  assign refresh = set_commit && arm;
  wdr_flag_timer #(
    .WINDOW(WINDOW)
  ) i_arm_flag (
    .i_clock(i_clock),
    .i_rst_n(i_rst_n),
    .i_clear(int_rst),
    .i_set(set_arm),
    .i_drop(refresh),
    .o_flag(arm)
  );
  wdr_flag_timer #(
    .WINDOW(WINDOW)
  ) i_commit_flag (
    .i_clock(i_clock),
    .i_rst_n(i_rst_n),
    .i_clear(int_rst),
    .i_set(set_commit),
    .i_drop(1'b0),
    .o_flag(commit)
  );

  // ----------------------------------------
  // run control
  // ----------------------------------------
  reg strap_seen;
  always @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      strap_seen <= 1'b0;
    end else if (int_rst) begin
      strap_seen <= i_auto_start;
    end else begin
      strap_seen <= 1'b0;
    end
  end
  // there is no stop path: software can start it but never halt it
  always @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_running <= 1'b0;
    end else if (int_rst) begin
      o_running <= 1'b0;
    end else if (strap_seen || set_commit) begin
      o_running <= 1'b1;
    end
  end

  // ----------------------------------------
  // prescaler
  // ----------------------------------------
  wire base_tick;
  wire extra_tick;
  wire extra_en;
  wire step;
  wdr_divider #(
    .DIV(BASE_DIV),
    .CNT_W(5)
  ) i_base_div (
    .i_clock(i_clock),
    .i_rst_n(i_rst_n),
    .i_clear(int_rst),
    .i_enable(o_running),
    .o_tick(base_tick)
  );
  assign extra_en = o_running && base_tick;
  wdr_divider #(
    .DIV(EXTRA_DIV),
    .CNT_W(4)
  ) i_extra_div (
    .i_clock(i_clock),
    .i_rst_n(i_rst_n),
    .i_clear(int_rst),
    .i_enable(extra_en),
    .o_tick(extra_tick)
  );
  assign step = o_running && base_tick && (!presel || extra_tick);

  // ----------------------------------------
  // watchdog counter
  // ----------------------------------------
  wire [15:0] load_value;
  wire count_match;
  assign load_value = {1'b0, reload_high, 8'h00};
  wdr_count #(
    .WIDTH(16),
    .TIMEOUT(`WDR_TIMEOUT)
  ) i_count (
    .i_clock(i_clock),
    .i_rst_n(i_rst_n),
    .i_clear(int_rst),
    .i_load(refresh),
    .i_load_value(load_value),
    .i_step(step),
    .o_count(),
    .o_match(count_match)
  );
  // decoded straight from the counter: clears as soon as it moves on
  assign o_timeout = o_running && count_match;

  // ----------------------------------------
  // timeout handling
  // ----------------------------------------
  // the request holds until the stretched internal reset takes it down
  always @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_reset_req <= 1'b0;
    end else if (int_rst) begin
      o_reset_req <= 1'b0;
    end else if (o_timeout) begin
      o_reset_req <= 1'b1;
    end
  end
  // sticky: a watchdog reset leaves it set so software can see the cause
  always @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_prio_wdt <= 1'b0;
    end else if (o_timeout) begin
      o_prio_wdt <= 1'b1;
    end
  end

  // ----------------------------------------
  // read port
  // ----------------------------------------
  // enable-one bit 6 reads back the status, never the commit bit
  reg [7:0] next_rdata;
  always @* begin
    next_rdata = 8'h00;
    if (i_rd) begin
      case (i_addr)
        `WDR_ADDR_RELOAD: next_rdata = reload;
        `WDR_ADDR_INT_ENABLE_REG_ZERO: next_rdata = {1'b0, arm, 6'h00};
        `WDR_ADDR_INT_ENABLE_REG_ONE: next_rdata = {1'b0, o_timeout, 6'h00};
        `WDR_ADDR_PRIO0: next_rdata = {1'b0, o_prio_wdt, 6'h00};
        default: next_rdata = 8'h00;
      endcase
    end
  end
  // data stands one cycle after the strobe, zero otherwise
  always @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rdata <= 8'h00;
    end else begin
      o_rdata <= next_rdata;
    end
  end
endmodule

// ----------------------------------------
// internal reset, raised after a held request
// ----------------------------------------
module wdr_rst_stretch #(
  parameter HOLD = `WDR_RST_HOLD,
  parameter CNT_W = 2
) (
  // clock and reset
  input wire i_clock,
  input wire i_rst_n,
  // request
  input wire i_cause,
  // reset out
  output reg o_int_rst
);
  reg [CNT_W-1:0] held;
  wire held_long;
  assign held_long = (held == HOLD - 1);
  // the pin forces the internal reset at once; a request must last HOLD cycles
  always @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      held <= {CNT_W{1'b0}};
      o_int_rst <= 1'b1;
    end else if (i_cause) begin
      if (held_long) begin
        o_int_rst <= 1'b1;
      end else begin
        held <= held + {{(CNT_W-1){1'b0}}, 1'b1};
      end
    end else begin
      held <= {CNT_W{1'b0}};
      o_int_rst <= 1'b0;
    end
  end
endmodule

// ----------------------------------------
// self-clearing flag with a fixed lifetime
// ----------------------------------------
module wdr_flag_timer #(
  parameter WINDOW = `WDR_WINDOW,
  parameter CNT_W = 4
) (
  // clock and reset
  input wire i_clock,
  input wire i_rst_n,
  // control
  input wire i_clear,
  input wire i_set,
  input wire i_drop,
  // state
  output reg o_flag
);
  reg [CNT_W-1:0] age;
  wire expired;
  assign expired = (age == WINDOW - 1);
  always @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_flag <= 1'b0;
      age <= {CNT_W{1'b0}};
    end else if (i_clear) begin
      o_flag <= 1'b0;
      age <= {CNT_W{1'b0}};
    end else if (i_set) begin
      // a fresh set wins over an expiry or drop in the same cycle
      o_flag <= 1'b1;
      age <= {CNT_W{1'b0}};
    end else if (o_flag && (i_drop || expired)) begin
      o_flag <= 1'b0;
    end else if (o_flag) begin
      age <= age + {{(CNT_W-1){1'b0}}, 1'b1};
    end
  end
endmodule

// ----------------------------------------
// free divider, ticks on its last count
// ----------------------------------------
module wdr_divider #(
  parameter DIV = `WDR_BASE_DIV,
  parameter CNT_W = 5
) (
  // clock and reset
  input wire i_clock,
  input wire i_rst_n,
  // control
  input wire i_clear,
  input wire i_enable,
  // tick
  output wire o_tick
);
  reg [CNT_W-1:0] phase;
  reg [CNT_W-1:0] next_phase;
  assign o_tick = (phase == DIV - 1);
  always @* begin
    next_phase = phase;
    if (i_enable) begin
      if (o_tick) begin
        next_phase = {CNT_W{1'b0}};
      end else begin
        next_phase = phase + {{(CNT_W-1){1'b0}}, 1'b1};
      end
    end
  end
  always @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      phase <= {CNT_W{1'b0}};
    end else if (i_clear) begin
      phase <= {CNT_W{1'b0}};
    end else begin
      phase <= next_phase;
    end
  end
endmodule

// ----------------------------------------
// watchdog count with reload and match
// ----------------------------------------
module wdr_count #(
  parameter WIDTH = 16,
  parameter [WIDTH-1:0] TIMEOUT = `WDR_TIMEOUT
) (
  // clock and reset
  input wire i_clock,
  input wire i_rst_n,
  // control
  input wire i_clear,
  input wire i_load,
  input wire [WIDTH-1:0] i_load_value,
  input wire i_step,
  // count and match
  output reg [WIDTH-1:0] o_count,
  output wire o_match
);
  always @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_count <= {WIDTH{1'b0}};
    end else if (i_clear) begin
      o_count <= {WIDTH{1'b0}};
    end else if (i_load) begin
      o_count <= i_load_value;
    end else if (i_step) begin
      o_count <= o_count + {{(WIDTH-1){1'b0}}, 1'b1};
    end
  end
  assign o_match = (o_count == TIMEOUT);
endmodule
`default_nettype wire

/* File: verification/wdr_watchdog_properties.sv */
`timescale 1ns/1ns
`default_nettype none
// ----
// port checks
// ----
module wdr_props (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic o_running,
  input wire logic o_timeout,
  input wire logic o_prio_wdt,
  input wire logic o_reset_req,
  input wire logic o_int_rst
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);
  a_stop_ignored: assert property (o_running && !o_int_rst |=> o_running || o_int_rst)
    else $error("stopped");
  // the strap restart lands two edges after the internal reset was last seen
  a_start_cause: assert property ($rose(o_running) |-> $past(o_int_rst, 2) ||
    ($past(i_wr) && $past(i_addr) == 8'hb8 && $past(i_wdata[6]))) else $error("start");
  a_timeout_run: assert property (o_timeout |-> o_running) else $error("idle");
  a_timeout_req: assert property ($rose(o_timeout) |=> o_reset_req && o_prio_wdt)
    else $error("no request");
  a_req_cause: assert property ($rose(o_reset_req) |-> $past(o_timeout))
    else $error("stray request");
  a_req_reset: assert property ($rose(o_reset_req) |-> ##[1:3] o_int_rst)
    else $error("no reset");
  a_reset_halts: assert property (o_int_rst && $past(o_int_rst) |=> !o_running)
    else $error("run in reset");
  a_status_clear: assert property (o_timeout |-> ##[1:6] !o_timeout)
    else $error("status stuck");
endmodule
bind wdr_watchdog wdr_props i_props (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_addr(i_addr),
  .i_wdata(i_wdata), .i_wr(i_wr), .o_running(o_running), .o_timeout(o_timeout),
  .o_prio_wdt(o_prio_wdt), .o_reset_req(o_reset_req), .o_int_rst(o_int_rst));
`default_nettype wire

/* File: verification/wdr_watchdog_tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
// ----
// watchdog bench
// ----
module wdr_watchdog_tb_top;
  logic i_clock = 1'b0, i_rst_n = 1'b0, i_auto_start = 1'b0, i_wr = 1'b0, i_rd = 1'b0;
  logic [7:0] i_addr = 8'h00, i_wdata = 8'h00;
  wire [7:0] o_rdata;
  wire o_running, o_timeout, o_prio_wdt, o_reset_req, o_int_rst;
  int n_mismatch = 0, compares = 0, cyc = 0, n;
  always #2 i_clock = ~i_clock;
  wdr_watchdog i_dut (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_auto_start(i_auto_start),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .o_running(o_running), .o_timeout(o_timeout), .o_prio_wdt(o_prio_wdt),
    .o_reset_req(o_reset_req), .o_int_rst(o_int_rst));
  task automatic give_verdict();
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %0t got %h want %h", $time, got, exp);
    end
  endtask
  // one access; a read compares its data in the cycle after the strobe
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clock);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= w;
    i_rd <= !w;
    @(posedge i_clock);
    i_wr <= 1'b0;
    i_rd <= 1'b0;
    #1 if (!w) chk(o_rdata, d);
  endtask
  always @(posedge i_clock) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      n_mismatch++;
      give_verdict();
    end
  end
  initial begin
    repeat (4) @(posedge i_clock);
    i_rst_n <= 1'b1;
    bus(0, 8'h86, 8'h00);
    bus(0, 8'ha8, 8'h00);
    bus(0, 8'hb8, 8'h00);
    bus(0, 8'ha9, 8'h00);
    bus(0, 8'h55, 8'h00);
    chk({7'h00, o_running}, 8'h00);
    bus(1, 8'h86, 8'hfc);
    bus(0, 8'h86, 8'hfc);
    bus(1, 8'h86, 8'h7c);
    // arm left to expire, so the commit starts without a reload
    bus(1, 8'ha8, 8'h40);
    bus(0, 8'ha8, 8'h40);
    repeat (13) @(posedge i_clock);
    bus(0, 8'ha8, 8'h00);
    bus(1, 8'hb8, 8'h40);
    chk({7'h00, o_running}, 8'h01);
    bus(1, 8'hb8, 8'h00);
    repeat (7000) @(posedge i_clock);
    chk({6'h00, o_reset_req, o_running}, 8'h01);
    // slow prescaler: 255 steps of 384 clocks cannot end within this wait
    bus(1, 8'h86, 8'hfc);
    bus(1, 8'ha8, 8'h40);
    bus(1, 8'hb8, 8'h40);
    repeat (6500) @(posedge i_clock);
    chk({6'h00, o_reset_req, o_timeout}, 8'h00);
    bus(1, 8'h86, 8'h7c);
    @(posedge i_clock);
    i_auto_start <= 1'b1;
    bus(1, 8'ha8, 8'h40);
    bus(1, 8'hb8, 8'h40);
    n = 0;
    while (o_timeout !== 1'b1 && n < 7000) begin
      @(negedge i_clock);
      n++;
    end
    // 0x7c00 to 0x7cff is 255 steps of 24 clocks, less the prescaler phase
    chk({7'h00, n >= 6090 && n <= 6130}, 8'h01);
    @(negedge i_clock);
    chk({6'h00, o_reset_req, o_prio_wdt}, 8'h03);
    repeat (2) @(negedge i_clock);
    chk({7'h00, o_int_rst}, 8'h01);
    repeat (10) @(negedge i_clock);
    chk({7'h00, o_running}, 8'h01);
    bus(0, 8'ha9, 8'h40);
    bus(0, 8'h86, 8'h7c);
    give_verdict();
  end
endmodule
`default_nettype wire
